//--- common/baud_gen_pkg.sv
// Constants, register map and carrier types for the serial baud-rate generator.
package baud_gen_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] BAUD_RATE_OFFSET = 8'h00;
    localparam logic [7:0] PRESCALER_OFFSET = 8'h04;
    localparam logic [7:0] CONFIG_OFFSET = 8'h08;
    localparam logic [7:0] STATUS_OFFSET = 8'h0c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LIN_TX_BIT = 6;
    localparam int LIN_RX_BIT = 5;
    localparam int FIRST_SEL_LSB = 3;
    localparam int RATE_SEL_LSB = 0;
    localparam int COARSE_SEL_LSB = 5;
    localparam int FINE_SEL_LSB = 0;
    localparam int SRC_SEL_BIT = 0;
    localparam int CHAR_LONG_BIT = 1;
    localparam int MODULE_EN_BIT = 2;
    localparam int BREAK_SEEN_BIT = 0;
    localparam int LINE_LEVEL_BIT = 1;
    localparam int BREAK_ACTIVE_BIT = 2;

    // ------------------------------------------------------------
    // Reset values and write masks
    // ------------------------------------------------------------
    localparam logic [7:0] BAUD_RATE_RESET = 8'h00;
    localparam logic [7:0] PRESCALER_RESET = 8'h00;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] BAUD_RATE_MASK = 8'h7f;
    localparam logic [7:0] CONFIG_MASK = 8'h07;

    // ------------------------------------------------------------
    // Divider and timing counts
    // ------------------------------------------------------------
    localparam logic [3:0] FIRST_DIV_0 = 4'h1;
    localparam logic [3:0] FIRST_DIV_1 = 4'h3;
    localparam logic [3:0] FIRST_DIV_2 = 4'h4;
    localparam logic [3:0] FIRST_DIV_3 = 4'hd;
    localparam logic [5:0] FINE_FRAME = 6'h20;
    localparam logic [1:0] QUAD_RATIO = 2'h3;
    localparam logic [2:0] FIXED_DIV = 3'h4;
    localparam logic [4:0] SAMPLES_PER_BIT = 5'h10;
    localparam logic [3:0] BREAK_NORMAL_SHORT = 4'ha;
    localparam logic [3:0] BREAK_NORMAL_LONG = 4'hb;
    localparam logic [3:0] BREAK_RX_LIN_SHORT = 4'hb;
    localparam logic [3:0] BREAK_RX_LIN_LONG = 4'hc;
    localparam logic [3:0] BREAK_TX_LIN_SHORT = 4'hd;
    localparam logic [3:0] BREAK_TX_LIN_LONG = 4'he;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic sample_tick;
        logic bit_tick;
    } baud_ticks_s;

    typedef struct packed {
        logic [3:0] rx_break_bits;
        logic [3:0] tx_break_bits;
        logic rx_lin_filter;
        logic tx_lin_break;
    } break_cfg_s;

endpackage

//--- core/tick_divider.sv
// Enable-pulse divider: passes one tick out of every div ticks in.
`timescale 1ns/1ps
module tick_divider
    import baud_gen_pkg::*;
#(
    parameter int WIDTH = 8
)
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    // Control
    input wire logic clear,
    input wire logic [WIDTH-1:0] div,
    // Ticks
    input wire logic tick_in,
    output logic tick_out
);

    logic [WIDTH-1:0] count_reg;
    logic last;

    // The output is combinational so that a chain of dividers adds no lag.
    assign last = (count_reg >= div - WIDTH'(1));
    assign tick_out = tick_in && last;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            count_reg <= '0;
        end
        else if (ce)
        begin
            if (clear)
            begin
                count_reg <= '0;
            end
            else if (tick_in)
            begin
                if (last)
                begin
                    count_reg <= '0;
                end
                else
                begin
                    count_reg <= count_reg + WIDTH'(1);
                end
            end
        end
    end

endmodule

//--- core/serial_baud_rate_generator.sv
// Baud-rate generator with LIN break-length control behind an AHB-Lite slave.
//
// Operation
// - One timing shared by receiver and transmitter.
// - LIN receive: 11 or 12 bit break.
// - LIN transmit: 13 or 14 bit break.
// - Both LIN bits combine; neither gives normal.
// - Receive filter rejects zero characters as breaks.
// - First prescaler divides by 1, 3, 4, 13.
// - Rate divisor is two to field power.
// - Reset clears rate divisor field.
// - Coarse field zero bypasses, else field plus one.
// - Coarse bypass also bypasses fine adjust.
// - Fine field inserts clocks per 32 outputs.
// - Rate is source over 64 times divisors.
// - Source is bus clock or quad clock.
`timescale 1ns/1ps
module serial_baud_rate_generator
    import baud_gen_pkg::*;
(
    // Clock, reset and freeze
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic ce,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Serial line input for break detection
    input wire logic rx_pin,
    // Timing and break outputs
    output baud_ticks_s ticks,
    output break_cfg_s break_cfg,
    output logic break_detect
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] baud_rate_reg;
    logic [7:0] prescaler_reg;
    logic [7:0] config_reg;
    logic break_seen_reg;
    logic [7:0] addr_reg;
    logic wr_pend_reg;
    logic [31:0] hrdata_reg;
    logic hreadyout_reg;
    logic addr_phase;
    logic wr_baud;
    logic wr_pre;
    logic wr_cfg;
    logic wr_stat;
    logic [31:0] read_mux;
    logic rx_sync_reg;
    logic in_break_reg;

    logic lin_tx;
    logic lin_rx;
    logic [1:0] first_sel;
    logic [2:0] rate_sel;
    logic [2:0] coarse_sel;
    logic [4:0] fine_sel;
    logic quad_bus_clock;
    logic char_long;
    logic serial_module_enable;

    assign lin_tx = baud_rate_reg[LIN_TX_BIT];
    assign lin_rx = baud_rate_reg[LIN_RX_BIT];
    assign first_sel = baud_rate_reg[FIRST_SEL_LSB +: 2];
    assign rate_sel = baud_rate_reg[RATE_SEL_LSB +: 3];
    assign coarse_sel = prescaler_reg[COARSE_SEL_LSB +: 3];
    assign fine_sel = prescaler_reg[FINE_SEL_LSB +: 5];
    assign quad_bus_clock = config_reg[SRC_SEL_BIT];
    assign char_long = config_reg[CHAR_LONG_BIT];
    assign serial_module_enable = config_reg[MODULE_EN_BIT];

    // Only single word transfers are used, so hsize is not decoded.
    assign addr_phase = hsel && htrans[1] && hready;
    assign wr_baud = wr_pend_reg && (addr_reg == BAUD_RATE_OFFSET);
    assign wr_pre = wr_pend_reg && (addr_reg == PRESCALER_OFFSET);
    assign wr_cfg = wr_pend_reg && (addr_reg == CONFIG_OFFSET);
    assign wr_stat = wr_pend_reg && (addr_reg == STATUS_OFFSET);

    // ------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            addr_reg <= 8'h00;
            wr_pend_reg <= 1'b0;
            hreadyout_reg <= 1'b1;
        end
        else if (ce)
        begin
            hreadyout_reg <= 1'b1;
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase)
            begin
                addr_reg <= haddr[7:0];
            end
        end
    end

    always_comb
    begin
        read_mux = 32'h0000_0000;
        if (haddr[7:0] == BAUD_RATE_OFFSET)
        begin
            read_mux[7:0] = baud_rate_reg;
        end
        else if (haddr[7:0] == PRESCALER_OFFSET)
        begin
            read_mux[7:0] = prescaler_reg;
        end
        else if (haddr[7:0] == CONFIG_OFFSET)
        begin
            read_mux[7:0] = config_reg;
        end
        else if (haddr[7:0] == STATUS_OFFSET)
        begin
            read_mux[BREAK_SEEN_BIT] = break_seen_reg;
            read_mux[LINE_LEVEL_BIT] = rx_sync_reg;
            read_mux[BREAK_ACTIVE_BIT] = in_break_reg;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            hrdata_reg <= 32'h0000_0000;
        end
        else if (ce && addr_phase && !hwrite)
        begin
            hrdata_reg <= read_mux;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            baud_rate_reg <= BAUD_RATE_RESET;
            prescaler_reg <= PRESCALER_RESET;
            config_reg <= CONFIG_RESET;
        end
        else if (ce)
        begin
            if (wr_baud)
            begin
                baud_rate_reg <= hwdata[7:0] & BAUD_RATE_MASK;
            end
            if (wr_pre)
            begin
                prescaler_reg <= hwdata[7:0];
            end
            if (wr_cfg)
            begin
                config_reg <= hwdata[7:0] & CONFIG_MASK;
            end
        end
    end

    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // Source clock and fine/coarse prescaler
    // ------------------------------------------------------------
    logic [1:0] quarter_reg;
    logic src_en;
    logic [3:0] coarse_cnt_reg;
    logic [4:0] fine_acc_reg;
    logic extra_reg;
    logic [3:0] period;
    logic [5:0] fine_sum;
    logic coarse_end;
    logic pre_en;
    logic chain_clear;

    assign chain_clear = !serial_module_enable;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            quarter_reg <= 2'h0;
        end
        else if (ce)
        begin
            quarter_reg <= quarter_reg + 2'h1;
        end
    end

    // Bus clock is one core clock in four
    assign src_en = quad_bus_clock || (quarter_reg == QUAD_RATIO);

    // Coarse divide by field plus one
    assign period = {1'b0, coarse_sel} + 4'h1 + {3'h0, extra_reg};
    assign coarse_end = src_en && (coarse_cnt_reg >= period - 4'h1);
    assign fine_sum = {1'b0, fine_acc_reg} + {1'b0, fine_sel};

    assign pre_en = (coarse_sel == 3'h0) ? src_en : coarse_end;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            coarse_cnt_reg <= 4'h0;
            fine_acc_reg <= 5'h00;
            extra_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (chain_clear || coarse_sel == 3'h0)
            begin
                coarse_cnt_reg <= 4'h0;
                fine_acc_reg <= 5'h00;
                extra_reg <= 1'b0;
            end
            else if (coarse_end)
            begin
                coarse_cnt_reg <= 4'h0;
                fine_acc_reg <= fine_sum[4:0];
                extra_reg <= (fine_sum >= FINE_FRAME);
            end
            else if (src_en)
            begin
                coarse_cnt_reg <= coarse_cnt_reg + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Fixed divider chain
    // ------------------------------------------------------------
    logic [3:0] first_div;
    logic [7:0] rate_div;
    logic first_en;
    logic rate_en;
    logic sample_en;
    logic bit_en;

    always_comb
    begin
        case (first_sel)
            2'h0: first_div = FIRST_DIV_0;
            2'h1: first_div = FIRST_DIV_1;
            2'h2: first_div = FIRST_DIV_2;
            default: first_div = FIRST_DIV_3;
        endcase
    end

    assign rate_div = 8'h01 << rate_sel;

    tick_divider #(.WIDTH(4)) first_stage (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .clear(chain_clear),
        .div(first_div),
        .tick_in(pre_en && serial_module_enable),
        .tick_out(first_en)
    );

    tick_divider #(.WIDTH(8)) rate_stage (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .clear(chain_clear),
        .div(rate_div),
        .tick_in(first_en),
        .tick_out(rate_en)
    );

    // Fixed four then sixteen gives 64
    tick_divider #(.WIDTH(3)) fixed_stage (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .clear(chain_clear),
        .div(FIXED_DIV),
        .tick_in(rate_en),
        .tick_out(sample_en)
    );

    tick_divider #(.WIDTH(5)) bit_stage (
        .core_clk(core_clk),
        .rstn(rstn),
        .ce(ce),
        .clear(chain_clear),
        .div(SAMPLES_PER_BIT),
        .tick_in(sample_en),
        .tick_out(bit_en)
    );

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ticks <= '0;
        end
        else if (ce)
        begin
            ticks.sample_tick <= sample_en;
            ticks.bit_tick <= bit_en;
        end
    end

    // ------------------------------------------------------------
    // Break lengths
    // ------------------------------------------------------------
    logic [3:0] rx_len;
    logic [3:0] tx_len;

    always_comb
    begin
        if (lin_rx)
        begin
            rx_len = char_long ? BREAK_RX_LIN_LONG : BREAK_RX_LIN_SHORT;
        end
        else
        begin
            rx_len = char_long ? BREAK_NORMAL_LONG : BREAK_NORMAL_SHORT;
        end
    end

    always_comb
    begin
        if (lin_tx)
        begin
            tx_len = char_long ? BREAK_TX_LIN_LONG : BREAK_TX_LIN_SHORT;
        end
        else
        begin
            tx_len = char_long ? BREAK_NORMAL_LONG : BREAK_NORMAL_SHORT;
        end
    end

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            break_cfg <= '0;
        end
        else if (ce)
        begin
            break_cfg.rx_break_bits <= rx_len;
            break_cfg.tx_break_bits <= tx_len;
            break_cfg.rx_lin_filter <= lin_rx;
            break_cfg.tx_lin_break <= lin_tx;
        end
    end

    // ------------------------------------------------------------
    // Receive break detector
    // ------------------------------------------------------------
    logic rx_meta_reg;
    logic [7:0] low_cnt_reg;
    logic [7:0] low_limit;
    logic break_hit;

    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rx_meta_reg <= 1'b1;
            rx_sync_reg <= 1'b1;
        end
        else if (ce)
        begin
            rx_meta_reg <= rx_pin;
            rx_sync_reg <= rx_meta_reg;
        end
    end

    assign low_limit = {rx_len, 4'h0};
    assign break_hit = !rx_sync_reg && !in_break_reg && sample_en
        && (low_cnt_reg == low_limit - 8'h01);

    // A break is reported once and re-armed only after the line returns high or the module is disabled.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            low_cnt_reg <= 8'h00;
            in_break_reg <= 1'b0;
            break_detect <= 1'b0;
        end
        else if (ce)
        begin
            break_detect <= break_hit;
            if (rx_sync_reg || chain_clear)
            begin
                low_cnt_reg <= 8'h00;
                in_break_reg <= 1'b0;
            end
            else if (break_hit)
            begin
                in_break_reg <= 1'b1;
            end
            else if (sample_en && !in_break_reg)
            begin
                low_cnt_reg <= low_cnt_reg + 8'h01;
            end
        end
    end

    // Set wins over a write-one clear in the same cycle.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            break_seen_reg <= 1'b0;
        end
        else if (ce)
        begin
            if (break_hit)
            begin
                break_seen_reg <= 1'b1;
            end
            else if (wr_stat && hwdata[BREAK_SEEN_BIT])
            begin
                break_seen_reg <= 1'b0;
            end
        end
    end

endmodule

//--- testbench/serial_baud_rate_generator_props.sv
// Port-level assertions for the serial baud-rate generator.
`timescale 1ns/1ps
module serial_baud_rate_generator_props
    import baud_gen_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rstn,
    // Bus and line inputs
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic rx_pin,
    // Outputs under watch
    input wire baud_ticks_s ticks,
    input wire break_cfg_s break_cfg,
    input wire logic break_detect
);
    // ----------------------------------------
    // Helpers and properties
    // ----------------------------------------
    logic [15:0] low_cnt_reg;
    wire tx_wbit = hwdata[LIN_TX_BIT];
    wire rx_wbit = hwdata[LIN_RX_BIT];

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // The line is timed here so a break pulse can be tied to how long it was low.
    always_ff @(posedge core_clk or negedge rstn)
    begin
        if (!rstn)
            low_cnt_reg <= 16'h0;
        else if (rx_pin)
            low_cnt_reg <= 16'h0;
        else if (low_cnt_reg != 16'hffff)
            low_cnt_reg <= low_cnt_reg + 16'h1;
    end

    sequence s_baud_write;
        hsel && htrans[1] && hready && ce && hwrite && haddr[7:0] == BAUD_RATE_OFFSET ##1 1'b1;
    endsequence

    a_bit_on_sample: assert property (
        ticks.bit_tick |-> ticks.sample_tick)
        else $error("bit tick without sample tick");
    a_sample_spacing: assert property (
        ticks.sample_tick |=> !ticks.sample_tick [*3])
        else $error("sample ticks closer than four cycles");
    a_rx_lin_len: assert property (
        break_cfg.rx_lin_filter |-> break_cfg.rx_break_bits inside {4'hb, 4'hc})
        else $error("receive break length out of range");
    a_tx_lin_len: assert property (
        break_cfg.tx_lin_break |-> break_cfg.tx_break_bits inside {4'hd, 4'he})
        else $error("transmit break length out of range");
    a_lin_len_pair: assert property (
        break_cfg.rx_lin_filter && break_cfg.tx_lin_break
        |-> break_cfg.tx_break_bits == break_cfg.rx_break_bits + 4'h2)
        else $error("combined break lengths do not pair");
    a_normal_len: assert property (
        $past(rstn) && !break_cfg.rx_lin_filter && !break_cfg.tx_lin_break
        |-> break_cfg.rx_break_bits == break_cfg.tx_break_bits
        && break_cfg.rx_break_bits inside {4'ha, 4'hb})
        else $error("ordinary break lengths wrong");
    a_break_min_low: assert property (
        break_detect |-> $past(low_cnt_reg, 4) >= 16'(break_cfg.rx_break_bits) * 16'h3c)
        else $error("break reported on a short low");
    a_break_single: assert property (
        break_detect |=> !break_detect)
        else $error("break pulse longer than one cycle");
    a_tx_follows_write: assert property (
        s_baud_write |=> ##1 break_cfg.tx_lin_break == $past(tx_wbit, 2))
        else $error("transmit break enable not applied");
    a_rx_follows_write: assert property (
        s_baud_write |=> ##1 break_cfg.rx_lin_filter == $past(rx_wbit, 2))
        else $error("receive break filter not applied");
endmodule

bind serial_baud_rate_generator serial_baud_rate_generator_props chk
(
    .core_clk(core_clk), .rstn(rstn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .rx_pin(rx_pin), .ticks(ticks),
    .break_cfg(break_cfg), .break_detect(break_detect)
);

//--- testbench/sw_bus_master.sv
// Software model that programs the generator over AHB-Lite.
`timescale 1ns/1ps
module sw_bus_master
    import baud_gen_pkg::*;
(
    // Clock
    input wire logic core_clk,
    // Request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Answer
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    // ----------------------------------------
    // Bus tasks
    // ----------------------------------------
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end

    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
        output logic [31:0] rdata);
        @(posedge core_clk);
        hsel <= 1'b1;
        haddr <= {24'h0, addr};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge core_clk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        do @(posedge core_clk); while (hready !== 1'b1);
        rdata = hrdata;
        // Released data lines must not keep showing the last word.
        hwdata <= ~wdata;
    endtask

    task automatic wr(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] unused;
        xfer(1'b1, addr, data, unused);
    endtask

    task automatic rd(input logic [7:0] addr, output logic [31:0] data);
        xfer(1'b0, addr, 32'h0, data);
    endtask

    // Module off first, since switching the clock path can glitch.
    task automatic set_rate(input logic [7:0] cfg, input logic [7:0] baud, input logic [7:0] psc);
        wr(CONFIG_OFFSET, {24'h0, cfg & ~(8'h1 << MODULE_EN_BIT)});
        wr(BAUD_RATE_OFFSET, {24'h0, baud});
        wr(PRESCALER_OFFSET, {24'h0, psc});
        wr(CONFIG_OFFSET, {24'h0, cfg});
    endtask
endmodule

//--- testbench/test_serial_baud_rate_generator.sv
// Self-checking testbench for the serial baud-rate generator.
`timescale 1ns/1ps
module test_serial_baud_rate_generator
    import baud_gen_pkg::*;
();
    // ----------------------------------------
    // Signals, model and tasks
    // ----------------------------------------
    logic core_clk;
    logic rstn;
    logic ce;
    logic rx_pin;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    baud_ticks_s ticks;
    break_cfg_s break_cfg;
    logic break_detect;
    int failures;
    int check_count;
    logic [31:0] seed;
    // Fields: source, first select, rate select, coarse select, fine select.
    localparam logic [13:0] RATE_TAB [7] = '{14'h2000, 14'h2905, 14'h3800, 14'h32ff,
        14'h0100, 14'h2700, 14'h2061};

    serial_baud_rate_generator dut (.core_clk(core_clk), .rstn(rstn), .ce(ce), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .rx_pin(rx_pin), .ticks(ticks), .break_cfg(break_cfg), .break_detect(break_detect));
    sw_bus_master p (.core_clk(core_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic int exp_period(logic [13:0] c);
        int first_div;
        int coarse_div;
        int fine;
        first_div = c[12:11] == 2'h0 ? 1 : c[12:11] == 2'h1 ? 3 : c[12:11] == 2'h2 ? 4 : 13;
        coarse_div = c[7:5] == 3'h0 ? 1 : int'(c[7:5]) + 1;
        fine = c[7:5] == 3'h0 ? 0 : int'(c[4:0]);
        return (64 * coarse_div + 2 * fine) * first_div * (1 << c[10:8]) * (c[13] ? 1 : 4);
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED %0t %s got %0h want %0h", $time, what, got, exp);
        end
    endtask

    task automatic summarize();
        if (failures == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic measure(output int per, output int smp);
        int n;
        n = 0;
        while (ticks.bit_tick !== 1'b1 && n < 40000)
        begin
            @(negedge core_clk);
            n++;
        end
        per = 0;
        smp = 0;
        do
        begin
            @(negedge core_clk);
            per++;
            smp += int'(ticks.sample_tick === 1'b1);
        end
        while (ticks.bit_tick !== 1'b1 && per < 40000);
    endtask

    task automatic run_rate(input logic [13:0] c);
        int per;
        int smp;
        p.set_rate({7'h0, c[13]} | 8'h04, {3'h0, c[12:8]}, c[7:0]);
        repeat (2)
        begin
            measure(per, smp);
            check(32'(per), 32'(exp_period(c)), "bit period");
            check(32'(smp), 32'h10, "samples per bit");
        end
        @(posedge core_clk);
        ce <= 1'b0;
        smp = 0;
        repeat (200)
        begin
            @(negedge core_clk);
            smp += int'(ticks.sample_tick === 1'b1);
        end
        check(32'(smp), 32'h0, "ticks while frozen");
        @(posedge core_clk);
        ce <= 1'b1;
    endtask

    task automatic run_break(input logic [2:0] k);
        int n;
        int rl;
        int tl;
        logic [31:0] st;
        rl = k[1] ? (k[0] ? 12 : 11) : (k[0] ? 11 : 10);
        tl = k[2] ? (k[0] ? 14 : 13) : (k[0] ? 11 : 10);
        p.set_rate({6'h0, k[0], 1'b1} | 8'h04, {1'b0, k[2:1], 5'h0}, 8'h00);
        repeat (3) @(negedge core_clk);
        check(32'(break_cfg.rx_break_bits), 32'(rl), "rx break length");
        check(32'(break_cfg.tx_break_bits), 32'(tl), "tx break length");
        check({30'h0, break_cfg.rx_lin_filter, break_cfg.tx_lin_break},
            {30'h0, k[1], k[2]}, "lin flags");
        @(posedge core_clk);
        rx_pin <= 1'b0;
        n = 0;
        do
        begin
            @(negedge core_clk);
            n++;
        end
        while (break_detect !== 1'b1 && n < 1000);
        check(32'(n >= rl * 64 - 6 && n <= rl * 64 + 10), 32'h1, "break detect time");
        p.rd(STATUS_OFFSET, st);
        check(st, 32'(1 << BREAK_SEEN_BIT | 1 << BREAK_ACTIVE_BIT), "break status");
        check({31'h0, hresp}, 32'h0, "okay response");
        @(posedge core_clk);
        rx_pin <= 1'b1;
        repeat (20) @(posedge core_clk);
        p.wr(STATUS_OFFSET, 32'h1);
        p.rd(STATUS_OFFSET, st);
        check(st, 32'(1 << LINE_LEVEL_BIT), "status after clear");
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    initial
    begin
        logic [31:0] d;
        logic [31:0] r;
        rstn = 1'b0;
        ce = 1'b1;
        rx_pin = 1'b1;
        failures = 0;
        check_count = 0;
        seed = 32'h0000005a;
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        p.rd(BAUD_RATE_OFFSET, d);
        check(d, 32'h0, "baud reset");
        p.rd(PRESCALER_OFFSET, d);
        check(d, 32'h0, "prescaler reset");
        p.wr(BAUD_RATE_OFFSET, 32'hffffffff);
        p.rd(BAUD_RATE_OFFSET, d);
        check(d, 32'h7f, "baud read back");
        r = xorshift();
        p.wr(8'h10, r);
        p.rd(8'h10, d);
        check(d, 32'h0, "unmapped read");
        p.wr(PRESCALER_OFFSET, r);
        p.rd(PRESCALER_OFFSET, d);
        check(d, {24'h0, r[7:0]}, "prescaler read back");
        foreach (RATE_TAB[i])
            run_rate(RATE_TAB[i]);
        r = xorshift();
        run_rate({1'b1, 2'h0, 2'h0, r[0], r[3:1] | 3'h1, r[8:4]});
        for (int k = 0; k < 8; k++)
            run_break(3'(k));
        summarize();
    end

    initial
    begin
        repeat (100000) @(posedge core_clk);
        failures++;
        summarize();
    end
endmodule
